/* File: rtl/stepper_ctrl_pkg.sv */
// Package: offsets, fields, reset values and timing for the control bank
package stepper_ctrl_pkg;

  // ---------------------------------------------------------------------
  // Register offsets and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_STEP_CONTROL       = 8'h05;
  localparam logic [7:0] ADDR_PROTECTION_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_STALL_SENSE_CONTROL = 8'h07;
  localparam logic [7:0] RST_STEP_CONTROL        = 8'h06;
  localparam logic [7:0] RST_PROTECTION_CONTROL  = 8'h38;
  localparam logic [7:0] RST_STALL_SENSE_CONTROL = 8'h49;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int BIT_HEADING      = 7;
  localparam int BIT_STEP         = 6;
  localparam int BIT_HEADING_SRC  = 5;
  localparam int BIT_PULSE_SRC    = 4;
  localparam int RES_HI           = 3;
  localparam int RES_LO           = 0;
  localparam int BIT_CLEAR_FLT    = 7;
  localparam int LOCK_HI          = 6;
  localparam int LOCK_LO          = 4;
  localparam int BIT_OC_DEGLITCH  = 3;
  localparam int BIT_OC_RECOVERY  = 2;
  localparam int BIT_OT_RECOVERY  = 1;
  localparam int BIT_TEMP_REPORT  = 0;
  localparam int BLANK_HI         = 7;
  localparam int BLANK_LO         = 6;
  localparam int BIT_STALL_LEARN  = 5;
  localparam int BIT_STALL_EN     = 4;
  localparam int BIT_STALL_REPORT = 3;
  localparam int BIT_FILT_BYPASS  = 2;
  localparam int TOL_HI           = 1;
  localparam int TOL_LO           = 0;

  // ---------------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] LOCK_KEY     = 3'h6;
  localparam logic [2:0] UNLOCK_KEY   = 3'h3;
  localparam logic [3:0] RES_MAX_CODE = 4'ha;

  // ---------------------------------------------------------------------
  // Timing: figures in ns, cycles at 100 MHz
  // ---------------------------------------------------------------------
  localparam int CLK_NS          = 10;
  localparam int OC_LONG_NS      = 2200;
  localparam int OC_SHORT_NS     = 1200;
  localparam int BLANK_BASE_NS   = 1000;
  localparam int BLANK_STEP_NS   = 500;
  localparam int OC_LONG_CYC     = (OC_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int OC_SHORT_CYC    = (OC_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_BASE_CYC  = (BLANK_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_STEP_CYC  = (BLANK_STEP_NS + CLK_NS - 1) / CLK_NS;

endpackage : stepper_ctrl_pkg

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_nrst,    // Async reset, active low
  input  wire logic [W-1:0] i_async,   // Pin levels
  output logic      [W-1:0] o_sync     // Synchronised levels
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // Next values
  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  // Register stages
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule : pin_sync

/* File: rtl/stepper_ctrl_registers.sv */
// Stepping, protection and stall control register bank
// What this block does
// - Writing 1 to step bit gives exactly one step when selected.
// - Step bit clears itself after a written 1.
// - Heading source 0 uses direction pin, 1 uses heading bit.
// - Pulse source 0 steps on pin, 1 only on step bit.
// - Four-bit resolution code selects step mode; 1011 and up reserved.
// - Writing 1 to clear bit clears all latched faults.
// - Clear bit returns to 0 immediately after a written 1.
// - Lock key 110 locks; then only lock field and clear writes act.
// - Unlock key 011 unlocks while locked; other values keep lock.
// - Overcurrent deglitch 2.2 us when 1, 1.2 us when 0.
// - Overcurrent recovery 0 latches, 1 auto-retries.
// - Overtemperature recovery 0 latches, 1 auto-retries.
// - Temperature warnings reach fault output only when report bit set.
// - Blanking code 00..11 gives 1, 1.5, 2, 2.5 us.
// - Writing 1 to stall-learn bit starts threshold learning.
// - Stall-learn bit stays 1 while learning, clears at completion.
// - Stall detect enable 0 disables, 1 enables detection.
// - Stall reaches fault output only when stall report set.
// - Filter bypass 0 filters step input, 1 passes it raw.
// - Tolerance code 00..11 gives 1, 2, 4, 6 percent.
`timescale 1ns/1ps
module stepper_ctrl_registers (
  input  wire logic       i_clk_sys,      // System clock 100 MHz
  input  wire logic       i_nrst,         // Async reset, active low
  input  wire logic       i_wr,           // Register write strobe
  input  wire logic       i_rd,           // Register read strobe
  input  wire logic [7:0] i_addr,         // Register offset
  input  wire logic [7:0] i_wdata,        // Write data
  output logic      [7:0] o_rdata,        // Read data, valid after i_rd
  input  wire logic       i_dir_pin,      // Direction pin, async
  input  wire logic       i_step_pin,     // Step pin, async
  input  wire logic       i_learn_done,   // Stall learning complete pulse
  input  wire logic       i_temp_warn,    // Temperature warning level
  input  wire logic       i_stall,        // Stall detected level
  input  wire logic       i_latched_flt,  // Any latched fault present
  output logic            o_heading,      // Effective direction, 1 fwd
  output logic            o_step_pulse,   // One-cycle indexer advance
  output logic      [3:0] o_substep_resolution, // Step mode code
  output logic            o_res_reserved, // Resolution code reserved
  output logic            o_clear_latched_faults, // Fault clear pulse
  output logic            o_locked,       // Write lock state
  output logic      [7:0] o_oc_deglitch_cyc, // Overcurrent filter cycles
  output logic            o_overcurrent_recovery_sel, // 1 auto-retry
  output logic            o_overtemp_recovery_sel,    // 1 auto-retry
  output logic      [7:0] o_blank_cyc,    // Sense blanking cycles
  output logic            o_stall_learn_active, // Learning running
  output logic            o_stall_detect_enable, // Stall detect on
  output logic            o_pulse_filter_bypass, // Step unfiltered
  output logic      [1:0] o_pulse_rate_filter_tol, // Filter tolerance
  output logic            o_fault_out_n   // Fault output, active low
);

  // ---------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------
  logic [1:0] pins_sync;

  pin_sync #(.W(2)) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_dir_pin, i_step_pin}),
    .o_sync    (pins_sync)
  );

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  logic [7:0] step_control;
  logic [7:0] protection_control;
  logic [7:0] stall_sense_control;
  logic       step_pin_q;
  logic [7:0] next_step_control;
  logic [7:0] next_protection_control;
  logic [7:0] next_stall_sense_control;
  logic       lock_state;
  logic       next_lock_state;
  logic       wr_step, wr_prot, wr_stall; // Decoded register writes

  // Cycles for a time figure held in the tables
  function automatic logic [7:0] blank_cycles(input logic [1:0] code);
    int c;
    c = stepper_ctrl_pkg::BLANK_BASE_CYC
        + int'(code) * stepper_ctrl_pkg::BLANK_STEP_CYC;
    return c[7:0];
  endfunction : blank_cycles

  // Lock field of a register byte
  function automatic logic [2:0] lock_code(input logic [7:0] r);
    return r[stepper_ctrl_pkg::LOCK_HI:stepper_ctrl_pkg::LOCK_LO];
  endfunction : lock_code

  // Address decode
  always_comb begin
    wr_step  = 1'b0;
    wr_prot  = 1'b0;
    wr_stall = 1'b0;
    if (i_addr == stepper_ctrl_pkg::ADDR_STEP_CONTROL) begin
      wr_step = i_wr;
    end else if (i_addr == stepper_ctrl_pkg::ADDR_PROTECTION_CONTROL) begin
      wr_prot = i_wr;
    end else if (i_addr == stepper_ctrl_pkg::ADDR_STALL_SENSE_CONTROL) begin
      wr_stall = i_wr;
    end
  end

  // Register next values
  always_comb begin
    next_step_control        = step_control;
    next_protection_control  = protection_control;
    next_stall_sense_control = stall_sense_control;
    next_lock_state          = lock_state;
    next_step_control[stepper_ctrl_pkg::BIT_STEP] = 1'b0;
    next_protection_control[stepper_ctrl_pkg::BIT_CLEAR_FLT] = 1'b0;
    if (wr_step && !lock_state) begin
      next_step_control = i_wdata;
    end
    if (wr_stall && !lock_state) begin
      next_stall_sense_control = i_wdata;
    end
    // completion wins over a write of the learn bit
    if (i_learn_done) begin
      next_stall_sense_control[stepper_ctrl_pkg::BIT_STALL_LEARN] = 1'b0;
    end
    if (wr_prot && !lock_state) begin
      next_protection_control = i_wdata;
      next_lock_state = lock_code(i_wdata) == stepper_ctrl_pkg::LOCK_KEY;
    end else if (wr_prot) begin
      next_protection_control[stepper_ctrl_pkg::BIT_CLEAR_FLT] =
        i_wdata[stepper_ctrl_pkg::BIT_CLEAR_FLT];
      next_lock_state = lock_code(i_wdata) != stepper_ctrl_pkg::UNLOCK_KEY;
    end
    // Lock field stores only the key of the current state
    next_protection_control[stepper_ctrl_pkg::LOCK_HI:
                            stepper_ctrl_pkg::LOCK_LO] =
      next_lock_state ? stepper_ctrl_pkg::LOCK_KEY :
                        stepper_ctrl_pkg::UNLOCK_KEY;
  end

  // Register storage
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      step_control        <= stepper_ctrl_pkg::RST_STEP_CONTROL;
      protection_control  <= stepper_ctrl_pkg::RST_PROTECTION_CONTROL;
      stall_sense_control <= stepper_ctrl_pkg::RST_STALL_SENSE_CONTROL;
      lock_state          <= 1'b0;
      step_pin_q          <= 1'b0;
    end else begin
      step_control        <= next_step_control;
      protection_control  <= next_protection_control;
      stall_sense_control <= next_stall_sense_control;
      lock_state          <= next_lock_state;
      step_pin_q          <= pins_sync[0];
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  logic       next_heading;
  logic       next_step_pulse;
  logic       next_fault_n;
  logic [7:0] next_rdata;
  logic [7:0] next_oc_cyc;

  // Output next values
  always_comb begin
    next_heading = step_control[stepper_ctrl_pkg::BIT_HEADING_SRC] ?
                   step_control[stepper_ctrl_pkg::BIT_HEADING] :
                   pins_sync[1];
    if (step_control[stepper_ctrl_pkg::BIT_PULSE_SRC]) begin
      next_step_pulse = step_control[stepper_ctrl_pkg::BIT_STEP];
    end else begin
      next_step_pulse = pins_sync[0] & ~step_pin_q;
    end
    next_oc_cyc = protection_control[stepper_ctrl_pkg::BIT_OC_DEGLITCH] ?
                  8'(stepper_ctrl_pkg::OC_LONG_CYC) :
                  8'(stepper_ctrl_pkg::OC_SHORT_CYC);
    next_fault_n = ~(i_latched_flt | (i_temp_warn &
      protection_control[stepper_ctrl_pkg::BIT_TEMP_REPORT]) |
      (i_stall & stall_sense_control[stepper_ctrl_pkg::BIT_STALL_EN] &
       stall_sense_control[stepper_ctrl_pkg::BIT_STALL_REPORT]));
    next_rdata = 8'h00;
    if (!i_rd) begin
      next_rdata = o_rdata;
    end else if (i_addr == stepper_ctrl_pkg::ADDR_STEP_CONTROL) begin
      next_rdata = step_control;
    end else if (i_addr == stepper_ctrl_pkg::ADDR_PROTECTION_CONTROL) begin
      next_rdata = protection_control;
    end else if (i_addr == stepper_ctrl_pkg::ADDR_STALL_SENSE_CONTROL) begin
      next_rdata = stall_sense_control;
    end
  end

  // Output registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_heading                  <= 1'b0;
      o_step_pulse               <= 1'b0;
      o_substep_resolution       <= 4'(stepper_ctrl_pkg::RST_STEP_CONTROL);
      o_res_reserved             <= 1'b0;
      o_clear_latched_faults     <= 1'b0;
      o_locked                   <= 1'b0;
      o_oc_deglitch_cyc          <= 8'(stepper_ctrl_pkg::OC_LONG_CYC);
      o_overcurrent_recovery_sel <= 1'b0;
      o_overtemp_recovery_sel    <= 1'b0;
      o_blank_cyc                <= 8'h00;
      o_stall_learn_active       <= 1'b0;
      o_stall_detect_enable      <= 1'b0;
      o_pulse_filter_bypass      <= 1'b0;
      o_pulse_rate_filter_tol    <=
        2'(stepper_ctrl_pkg::RST_STALL_SENSE_CONTROL);
      o_fault_out_n              <= 1'b1;
      o_rdata                    <= 8'h00;
    end else begin
      o_heading                  <= next_heading;
      o_step_pulse               <= next_step_pulse;
      o_substep_resolution       <= step_control[stepper_ctrl_pkg::RES_HI:
                                                 stepper_ctrl_pkg::RES_LO];
      o_res_reserved             <= step_control[stepper_ctrl_pkg::RES_HI:
                                     stepper_ctrl_pkg::RES_LO] >
                                    stepper_ctrl_pkg::RES_MAX_CODE;
      o_clear_latched_faults     <=
        protection_control[stepper_ctrl_pkg::BIT_CLEAR_FLT];
      o_locked                   <= lock_state;
      o_oc_deglitch_cyc          <= next_oc_cyc;
      o_overcurrent_recovery_sel <=
        protection_control[stepper_ctrl_pkg::BIT_OC_RECOVERY];
      o_overtemp_recovery_sel    <=
        protection_control[stepper_ctrl_pkg::BIT_OT_RECOVERY];
      o_blank_cyc                <= blank_cycles(stall_sense_control[
        stepper_ctrl_pkg::BLANK_HI:stepper_ctrl_pkg::BLANK_LO]);
      o_stall_learn_active       <=
        stall_sense_control[stepper_ctrl_pkg::BIT_STALL_LEARN];
      o_stall_detect_enable      <=
        stall_sense_control[stepper_ctrl_pkg::BIT_STALL_EN];
      o_pulse_filter_bypass      <=
        stall_sense_control[stepper_ctrl_pkg::BIT_FILT_BYPASS];
      o_pulse_rate_filter_tol    <= stall_sense_control[
        stepper_ctrl_pkg::TOL_HI:stepper_ctrl_pkg::TOL_LO];
      o_fault_out_n              <= next_fault_n;
      o_rdata                    <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_step_once;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (wr_step && !lock_state && i_wdata[stepper_ctrl_pkg::BIT_STEP] &&
       i_wdata[stepper_ctrl_pkg::BIT_PULSE_SRC])
      |-> ##2 o_step_pulse ##1 !o_step_pulse;
  endproperty
  a_step_once: assert property (p_step_once)
    else $error("register step did not give one pulse");
  property p_step_clear;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      step_control[stepper_ctrl_pkg::BIT_STEP] |=>
        !step_control[stepper_ctrl_pkg::BIT_STEP] || $past(wr_step);
  endproperty
  a_step_clear: assert property (p_step_clear)
    else $error("step bit did not self clear");
  property p_heading_src;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      ##1 (o_heading == ($past(step_control[stepper_ctrl_pkg::BIT_HEADING_SRC])
        ? $past(step_control[stepper_ctrl_pkg::BIT_HEADING])
        : $past(pins_sync[1])));
  endproperty
  a_heading_src: assert property (p_heading_src)
    else $error("heading source wrong");
  property p_clear_pulse;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (wr_prot && i_wdata[stepper_ctrl_pkg::BIT_CLEAR_FLT])
      |-> ##2 o_clear_latched_faults ##1 !o_clear_latched_faults;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("fault clear not one pulse");
  property p_lock;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (wr_prot && !lock_state &&
       lock_code(i_wdata) == stepper_ctrl_pkg::LOCK_KEY)
      |=> lock_state ##1 o_locked;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock key did not lock");
  property p_locked_ignore;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (lock_state && (wr_step || wr_stall) && !i_learn_done)
      |=> $stable(stall_sense_control[stepper_ctrl_pkg::BIT_STALL_EN]) &&
          $stable(step_control[stepper_ctrl_pkg::RES_HI:
                               stepper_ctrl_pkg::RES_LO]);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore)
    else $error("write acted while locked");
  property p_unlock;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (wr_prot && lock_state) |=> (lock_state ==
        ($past(lock_code(i_wdata)) != stepper_ctrl_pkg::UNLOCK_KEY));
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock key handling wrong");
  property p_learn_end;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_learn_done |=> !stall_sense_control[stepper_ctrl_pkg::BIT_STALL_LEARN];
  endproperty
  a_learn_end: assert property (p_learn_end)
    else $error("learn bit not cleared at completion");
  property p_stall_report;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_stall && !stall_sense_control[stepper_ctrl_pkg::BIT_STALL_REPORT]
       && !i_latched_flt && !i_temp_warn) |=> o_fault_out_n;
  endproperty
  a_stall_report: assert property (p_stall_report)
    else $error("stall reported while masked");

endmodule : stepper_ctrl_registers

/* File: testbench/host_model.sv */
// Host model: drives the register strobes of the control bank
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_clk_sys, // System clock
  input  wire logic [7:0] i_rdata,   // Read data from the bank
  output logic            o_wr,      // Write strobe
  output logic            o_rd,      // Read strobe
  output logic      [7:0] o_addr,    // Register offset
  output logic      [7:0] o_wdata    // Write data
);
  // Idle bus at time zero
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'hff;
    o_wdata = 8'h00;
  end

  // One-cycle write; released lines show the inverse, never the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr

  // One-cycle read; data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk_sys);
    d = i_rdata;
  endtask : rd
endmodule : host_model

/* File: testbench/tb_top.sv */
// Testbench: self-checking run of the stepping and protection bank
`timescale 1ns/1ps
// Compare, count and report one value
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((e) !== (g)) begin \
    mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end
module tb_top;
  logic       i_clk_sys = 1'b0, i_nrst = 1'b0, i_dir_pin = 1'b0;
  logic       i_step_pin = 1'b0, i_learn_done = 1'b0, i_temp_warn = 1'b0;
  logic       i_stall = 1'b0, i_latched_flt = 1'b0, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, o_oc_deglitch_cyc, o_blank_cyc;
  logic [3:0] o_substep_resolution;
  logic [1:0] o_pulse_rate_filter_tol;
  logic       o_heading, o_step_pulse, o_res_reserved, o_locked;
  logic       o_clear_latched_faults, o_overcurrent_recovery_sel;
  logic       o_overtemp_recovery_sel, o_stall_learn_active, o_fault_out_n;
  logic       o_stall_detect_enable, o_pulse_filter_bypass;
  logic [7:0] v, lf, d;
  int         mismatches = 0, comparisons = 0, cyc = 0, nsteps, nclr;

  // ---------------------------------------------------------------------
  // Clock, pulse counters and timeout
  // ---------------------------------------------------------------------
  always #5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_step_pulse === 1'b1) nsteps++;
    if (o_clear_latched_faults === 1'b1) nclr++;
    if (cyc == 4000) begin
      mismatches++;
      results();
    end
  end

  stepper_ctrl_registers stepper_ctrl_registers_i (.i_clk_sys, .i_nrst,
    .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .i_dir_pin, .i_step_pin,
    .i_learn_done, .i_temp_warn, .i_stall, .i_latched_flt, .o_heading,
    .o_step_pulse, .o_substep_resolution, .o_res_reserved,
    .o_clear_latched_faults, .o_locked, .o_oc_deglitch_cyc,
    .o_overcurrent_recovery_sel, .o_overtemp_recovery_sel, .o_blank_cyc,
    .o_stall_learn_active, .o_stall_detect_enable, .o_pulse_filter_bypass,
    .o_pulse_rate_filter_tol, .o_fault_out_n);
  host_model host_model_i (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata),
    .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] blank_exp(input logic [1:0] c);
    return 8'h64 + 8'h32 * {6'h00, c};
  endfunction : blank_exp
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    host_model_i.rd(a, v);
    `CHK("rdata", e, v)
  endtask : chkrd
  task automatic wrs(input logic [7:0] a, input logic [7:0] e);
    host_model_i.wr(a, e);
    repeat (8) @(posedge i_clk_sys);
  endtask : wrs
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    chkrd(8'h05, 8'h06);
    chkrd(8'h06, 8'h38);
    chkrd(8'h07, 8'h49);
    chkrd(8'h08, 8'h00);
    `CHK("dgl", 8'hdc, o_oc_deglitch_cyc)
    `CHK("blank", 8'h96, o_blank_cyc)
    // Register step, pin ignored meanwhile
    wrs(8'h05, 8'h10);
    nsteps = 0;
    i_step_pin <= 1'b1;
    wrs(8'h05, 8'h50);
    `CHK("steps", 1, nsteps)
    chkrd(8'h05, 8'h10);
    i_step_pin <= 1'b0;
    wrs(8'h05, 8'h00);
    nsteps = 0;
    i_step_pin <= 1'b1;
    wrs(8'h05, 8'h00);
    `CHK("pin steps", 1, nsteps)
    i_dir_pin <= 1'b1;
    wrs(8'h05, 8'h20);
    `CHK("heading", 1'b0, o_heading)
    wrs(8'h05, 8'ha0);
    `CHK("heading", 1'b1, o_heading)
    wrs(8'h05, 8'h00);
    `CHK("heading", 1'b1, o_heading)
    // Every resolution code, reserved ones included
    for (int i = 0; i < 16; i++) begin
      wrs(8'h05, 8'(i));
      `CHK("res", 4'(i), o_substep_resolution)
      `CHK("rsv", 1'(i > 10), o_res_reserved)
    end
    wrs(8'h06, 8'h36);
    `CHK("dgl", 8'h78, o_oc_deglitch_cyc)
    `CHK("ocr", 1'b1, o_overcurrent_recovery_sel)
    `CHK("otr", 1'b1, o_overtemp_recovery_sel)
    i_temp_warn <= 1'b1;
    wrs(8'h06, 8'h31);
    `CHK("fault", 1'b0, o_fault_out_n)
    wrs(8'h06, 8'h30);
    `CHK("fault", 1'b1, o_fault_out_n)
    i_temp_warn <= 1'b0;
    i_latched_flt <= 1'b1;
    nclr = 0;
    wrs(8'h06, 8'hb8);
    `CHK("fault", 1'b0, o_fault_out_n)
    `CHK("clears", 1, nclr)
    chkrd(8'h06, 8'h38);
    i_latched_flt <= 1'b0;
    // Lock keys, refused writes while locked
    wrs(8'h06, 8'h48);
    `CHK("lock", 1'b0, o_locked)
    wrs(8'h06, 8'h68);
    `CHK("lock", 1'b1, o_locked)
    wrs(8'h05, 8'h0a);
    chkrd(8'h05, 8'h0f);
    wrs(8'h06, 8'h51);
    chkrd(8'h06, 8'h68);
    nclr = 0;
    wrs(8'h06, 8'he8);
    `CHK("clears", 1, nclr)
    wrs(8'h06, 8'h38);
    `CHK("lock", 1'b0, o_locked)
    // Stall reporting and learning
    i_stall <= 1'b1;
    wrs(8'h07, 8'h18);
    `CHK("fault", 1'b0, o_fault_out_n)
    wrs(8'h07, 8'h10);
    `CHK("fault", 1'b1, o_fault_out_n)
    wrs(8'h07, 8'h08);
    `CHK("stall en", 1'b0, o_stall_detect_enable)
    i_stall <= 1'b0;
    wrs(8'h07, 8'h20);
    `CHK("learn", 1'b1, o_stall_learn_active)
    chkrd(8'h07, 8'h20);
    i_learn_done <= 1'b1;
    @(posedge i_clk_sys);
    i_learn_done <= 1'b0;
    chkrd(8'h07, 8'h00);
    // Random settings of the stall and filter register
    lf = 8'h0a;
    repeat (20) begin
      lf = lfsr(lf);
      d = lf & 8'hdf;
      wrs(8'h07, d);
      `CHK("blank", blank_exp(d[7:6]), o_blank_cyc)
      `CHK("stall en", d[4], o_stall_detect_enable)
      `CHK("bypass", d[2], o_pulse_filter_bypass)
      `CHK("tol", d[1:0], o_pulse_rate_filter_tol)
      chkrd(8'h07, d);
    end
    results();
  end
endmodule : tb_top
